// ---- hw/aahrm_regbank.sv ----
// Host register bank of a multichannel acquisition board, with buffer,
// rate generators, burst control and trigger/clock sync pins.
// Assumes the bus bridge issues one-cycle longword read/write strobes.
// Operation
// - Trigger initiator drives sync pin to targets; targets start bursts on it.
// - Clock initiator drives clock sync pin; targets sample on its falling edges.
// - Host side runs from a 33 or 66 MHz bridge, 32-bit data.
// - Normal decode window is sixteen longwords on any such boundary.
// - Direct read mode extends decoded window to 0x200 bytes.
// - Every register access is one full 32-bit longword.
// - All interrupt conditions merge onto one interrupt request.
// - DMA reads drain the input buffer toward the host only.
// - Main control word at 0x0000, read/write, reset 0x00004060.
// - Interrupt condition and flag word at 0x0004, reset 0x00000008.
// - Reading 0x0008 returns the next buffered value.
// - Buffer threshold and control at 0x000C, reset 0x0003FFFE.
// - Rate generators at 0x0010 and 0x0014 with their reset values.
// - Fill count at 0x0018 is read-only, zero after reset.
// - Clocks per burst at 0x001C, reset one.
// - Scan, clock and trigger source selections at 0x0020, reset 5.
// - First and last channel at 0x0024, reset 0x00000100.
// - Firmware revision and option straps read at 0x0028.
// - Auxiliary sync port control at 0x0034, reset zero.
// - Scan marker halves at 0x0038 and 0x003C, reset zero.
// - Low latency words at 0x0100-0x01FC; 0x0040-0x00FC reserved.
// - Calibration readback word at 0x002C is read/write.
`timescale 1ns/10ps
`default_nettype none
module aahrm_regbank
  import aahrm_pkg::*;
#(
  parameter int FIFO_DEPTH = 256,
  parameter int FIFO_AW = 8,
  parameter int CHAN_N = 64,
  parameter logic [7:0] FW_REV = 8'h01 // Arbitrary revision value
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] lb_addr,
  input wire logic lb_rd,
  input wire logic lb_wr,
  input wire logic [31:0] lb_wdata,
  output logic [31:0] lb_rdata_ff,
  output logic lb_ack_ff,
  output logic lb_hit,
  input wire logic direct_mode_sel,
  output logic irq_req,
  output logic dma_req,
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic [17:0] samp_data,
  input wire logic [5:0] samp_chan,
  output logic samp_strobe_ff,
  input wire logic [7:0] option_straps,
  input wire logic trig_sync_in,
  output logic trig_sync_out,
  output logic trig_sync_oe_n,
  input wire logic clk_sync_in,
  output logic clk_sync_out,
  output logic clk_sync_oe_n,
  output logic [31:0] aux_sync_ctrl
);
  initial begin
    if (FIFO_DEPTH != (1 << FIFO_AW) || FIFO_AW > THR_W ||
        CHAN_N != 64) begin
      $error("aahrm_regbank: unsupported parameters");
    end
  end

  logic [31:0] ctrl_ff, irq_ff, thr_ff, rate_a_ff, rate_b_ff, burst_ff;
  logic [31:0] scan_ff, span_ff, cal_ff, aux_ff, mark_hi_ff, mark_lo_ff;
  logic [7:0] straps_ff;
  logic [17:0] fifo_mem [FIFO_DEPTH];
  logic [17:0] latest_mem [CHAN_N];
  logic [FIFO_AW-1:0] wptr_ff, rptr_ff;
  logic [FIFO_AW:0] fill_ff;
  logic [17:0] sk_d0_ff, sk_d1_ff;
  logic [1:0] sk_n_ff;
  logic [2:0] trig_sy_ff, clk_sy_ff;
  logic [DIV_W-1:0] cnt_a_ff, cnt_b_ff;
  logic [31:0] bcnt_ff;
  logic [7:0] tpulse_ff, cpulse_ff;
  logic thr_hit_ff;
  aahrm_burst_t burst_st_ff;

  // Decode
  logic in_norm, in_direct, is_rd, is_wr;
  logic [5:0] word_idx;
  assign in_norm = lb_addr < NORMAL_TOP;
  assign in_direct = direct_mode_sel && lb_addr >= DIRECT_BASE;
  assign lb_hit = in_norm || in_direct || direct_mode_sel;
  // Low two address bits ignored: longword only, no lanes
  assign is_rd = clk_en && lb_rd;
  assign is_wr = clk_en && lb_wr && in_norm;
  assign word_idx = lb_addr[7:2];

  function automatic logic wr_at(input logic [8:0] ofs);
    wr_at = is_wr && lb_addr[8:2] == ofs[8:2];
  endfunction : wr_at

  // Buffer status
  logic fifo_full, fifo_empty, fifo_pop, fifo_push, buf_clr;
  logic under_ev, over_ev;
  assign fifo_full = fill_ff == (FIFO_AW+1)'(FIFO_DEPTH);
  assign fifo_empty = fill_ff == '0;
  assign fifo_pop = is_rd && in_norm && lb_addr[8:2] == OFS_FIFO[8:2]
                    && !fifo_empty;
  assign under_ev = is_rd && in_norm && lb_addr[8:2] == OFS_FIFO[8:2]
                    && fifo_empty;
  assign fifo_push = sk_n_ff != 2'd0 && !fifo_full;
  assign over_ev = clk_en && sk_n_ff == 2'd2 && fifo_full && samp_valid;
  assign buf_clr = wr_at(OFS_THR) && lb_wdata[B_BUF_CLR];
  assign dma_req = !fifo_empty;

  // Sample sequencing
  logic trig_fall, clk_fall, tick_a, tick_b, samp_tick, trig_ev;
  logic [1:0] csrc, tsrc;
  assign trig_fall = trig_sy_ff[2] && !trig_sy_ff[1];
  assign clk_fall = clk_sy_ff[2] && !clk_sy_ff[1];
  assign tick_a = !rate_a_ff[B_RATE_OFF] && cnt_a_ff == '0;
  assign tick_b = !rate_b_ff[B_RATE_OFF] && cnt_b_ff == '0;
  assign csrc = scan_ff[CLK_SRC_LSB +: 2];
  assign tsrc = scan_ff[TRG_SRC_LSB +: 2];

  always_comb begin
    unique case (csrc)
      CSRC_RATE_A: samp_tick = tick_a;
      CSRC_RATE_B: samp_tick = tick_b;
      CSRC_EXT: samp_tick = clk_fall;
      CSRC_CTRL: samp_tick = ctrl_ff[B_ICLK];
    endcase
  end

  always_comb begin
    unique case (tsrc)
      TSRC_NONE: trig_ev = 1'b0;
      TSRC_EXT: trig_ev = trig_fall;
      TSRC_CTRL: trig_ev = ctrl_ff[B_TRIG];
      TSRC_RATE_B: trig_ev = tick_b;
    endcase
  end

  logic samp_go, burst_start, burst_end;
  assign burst_start = clk_en && trig_ev && burst_st_ff == AAHRM_BURST_IDLE;
  assign samp_go = clk_en && samp_tick &&
                   (tsrc == TSRC_NONE || burst_st_ff == AAHRM_BURST_RUN);
  assign burst_end = samp_go && burst_st_ff == AAHRM_BURST_RUN &&
                     bcnt_ff + 32'h0000_0001 >= burst_ff;

  logic init_go;
  assign init_go = ctrl_ff[B_INIT];

  // Main control word
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (clk_en && init_go)) begin
      ctrl_ff <= RST_CTRL;
    end else if (clk_en) begin
      if (wr_at(OFS_CTRL)) begin
        ctrl_ff <= (lb_wdata & CTRL_RW_MASK) | (ctrl_ff & ~CTRL_RW_MASK);
      end else begin
        ctrl_ff[B_TRIG] <= 1'b0;
        ctrl_ff[B_ICLK] <= 1'b0;
        ctrl_ff[B_ACAL] <= 1'b0;
      end
      ctrl_ff[B_PASS] <= 1'b1;
      ctrl_ff[B_HOLD] <= 1'b0;
      // Hardware set beats a clearing write or buffer clear
      if (under_ev) begin
        ctrl_ff[B_UNDER] <= 1'b1;
      end else if (buf_clr) begin
        ctrl_ff[B_UNDER] <= 1'b0;
      end
      if (over_ev) begin
        ctrl_ff[B_OVER] <= 1'b1;
      end else if (buf_clr) begin
        ctrl_ff[B_OVER] <= 1'b0;
      end
    end
  end

  // Interrupt conditions; flags written to zero clear them
  logic [IRQ_N-1:0] ev_vec, nxt_flags;
  logic thr_now;
  assign thr_now = {{(THR_W-FIFO_AW-1){1'b0}}, fill_ff} > thr_ff[THR_W-1:0];
  assign ev_vec = {thr_now && !thr_hit_ff, burst_end, burst_start,
                   clk_en && init_go};
  always_comb begin
    nxt_flags = irq_ff[IRQ_FLAG_LSB +: IRQ_N];
    if (wr_at(OFS_IRQ)) begin
      nxt_flags = lb_wdata[IRQ_FLAG_LSB +: IRQ_N];
    end
    nxt_flags = nxt_flags | ev_vec;
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_ff <= RST_IRQ;
      thr_hit_ff <= 1'b0;
    end else if (clk_en) begin
      if (init_go) begin
        irq_ff <= RST_IRQ;
        irq_ff[IRQ_FLAG_LSB + EV_INIT] <= 1'b1;
      end else begin
        if (wr_at(OFS_IRQ)) begin
          irq_ff[IRQ_N-1:0] <= lb_wdata[IRQ_N-1:0];
        end
        irq_ff[IRQ_FLAG_LSB +: IRQ_N] <= nxt_flags;
      end
      thr_hit_ff <= thr_now;
    end
  end
  assign irq_req = |(irq_ff[IRQ_FLAG_LSB +: IRQ_N] & irq_ff[IRQ_N-1:0]);

  // Plain read/write words
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (clk_en && init_go)) begin
      thr_ff <= RST_THR;
      rate_a_ff <= RST_RATE_A;
      rate_b_ff <= RST_RATE_B;
      burst_ff <= RST_BURST;
      scan_ff <= RST_SCAN;
      span_ff <= RST_SPAN;
      aux_ff <= ZERO32;
      mark_hi_ff <= ZERO32;
      mark_lo_ff <= ZERO32;
    end else if (clk_en) begin
      if (wr_at(OFS_THR)) begin
        thr_ff <= lb_wdata & ~(32'h0000_0001 << B_BUF_CLR);
      end
      if (wr_at(OFS_RATE_A)) begin
        rate_a_ff <= lb_wdata;
      end
      if (wr_at(OFS_RATE_B)) begin
        rate_b_ff <= lb_wdata;
      end
      if (wr_at(OFS_BURST)) begin
        burst_ff <= lb_wdata;
      end
      if (wr_at(OFS_SCAN)) begin
        scan_ff <= lb_wdata;
      end
      if (wr_at(OFS_SPAN)) begin
        span_ff <= lb_wdata;
      end
      if (wr_at(OFS_AUX)) begin
        aux_ff <= lb_wdata;
      end
      if (wr_at(OFS_MARK_HI)) begin
        mark_hi_ff <= {16'h0000, lb_wdata[15:0]};
      end
      if (wr_at(OFS_MARK_LO)) begin
        mark_lo_ff <= {16'h0000, lb_wdata[15:0]};
      end
    end
  end
  assign aux_sync_ctrl = aux_ff;

  // Calibration values survive initialization
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cal_ff <= RST_CAL;
    end else if (clk_en && wr_at(OFS_CAL)) begin
      cal_ff <= lb_wdata;
    end
  end

  // Straps caught on every enabled cycle, under reset as well
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      straps_ff <= option_straps;
    end
  end

  // Two-entry skid buffer so a full store stalls the source
  assign samp_ready = sk_n_ff != 2'd2;
  logic sk_in;
  assign sk_in = clk_en && samp_valid && samp_ready;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (clk_en && (init_go || buf_clr))) begin
      sk_n_ff <= 2'd0;
    end else if (clk_en) begin
      unique case ({sk_in, fifo_push})
        2'b10: begin
          sk_n_ff <= sk_n_ff + 2'd1;
          if (sk_n_ff == 2'd0) begin
            sk_d0_ff <= samp_data;
          end else begin
            sk_d1_ff <= samp_data;
          end
        end
        2'b01: begin
          sk_n_ff <= sk_n_ff - 2'd1;
          sk_d0_ff <= sk_d1_ff;
        end
        2'b11: begin
          if (sk_n_ff == 2'd1) begin
            sk_d0_ff <= samp_data;
          end else begin
            sk_d0_ff <= sk_d1_ff;
            sk_d1_ff <= samp_data;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Newest value per channel for the direct window
  always_ff @(posedge sys_clk) begin
    if (sk_in) begin
      latest_mem[samp_chan] <= samp_data;
    end
  end

  // Input buffer
  always_ff @(posedge sys_clk) begin
    if (clk_en && fifo_push) begin
      fifo_mem[wptr_ff] <= sk_d0_ff;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (clk_en && (init_go || buf_clr))) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      fill_ff <= '0;
    end else if (clk_en) begin
      if (fifo_push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (fifo_pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      unique case ({fifo_push, fifo_pop})
        2'b10: fill_ff <= fill_ff + 1'b1;
        2'b01: fill_ff <= fill_ff - 1'b1;
        default: fill_ff <= fill_ff;
      endcase
    end
  end

  // Read mux, answered one cycle after the strobe
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = ZERO32;
    if (in_direct) begin
      nxt_rdata = {14'h0000, latest_mem[word_idx]};
    end else if (in_norm) begin
      unique case (lb_addr[5:2])
        OFS_CTRL[5:2]: nxt_rdata = ctrl_ff;
        OFS_IRQ[5:2]: nxt_rdata = irq_ff;
        OFS_FIFO[5:2]: nxt_rdata = {14'h0000, fifo_mem[rptr_ff]};
        OFS_THR[5:2]: nxt_rdata = thr_ff;
        OFS_RATE_A[5:2]: nxt_rdata = rate_a_ff;
        OFS_RATE_B[5:2]: nxt_rdata = rate_b_ff;
        OFS_FILL[5:2]: nxt_rdata = {{(31-FIFO_AW){1'b0}}, fill_ff};
        OFS_BURST[5:2]: nxt_rdata = burst_ff;
        OFS_SCAN[5:2]: nxt_rdata = scan_ff;
        OFS_SPAN[5:2]: nxt_rdata = span_ff;
        OFS_BUILD[5:2]: nxt_rdata = {16'h0000, FW_REV, straps_ff};
        OFS_CAL[5:2]: nxt_rdata = cal_ff;
        OFS_SPARE[5:2]: nxt_rdata = ZERO32;
        OFS_AUX[5:2]: nxt_rdata = aux_ff;
        OFS_MARK_HI[5:2]: nxt_rdata = mark_hi_ff;
        OFS_MARK_LO[5:2]: nxt_rdata = mark_lo_ff;
      endcase
      if (fifo_empty && lb_addr[5:2] == OFS_FIFO[5:2]) begin
        nxt_rdata = ZERO32;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lb_rdata_ff <= ZERO32;
      lb_ack_ff <= 1'b0;
    end else if (clk_en) begin
      lb_ack_ff <= lb_rd || lb_wr;
      if (lb_rd) begin
        lb_rdata_ff <= nxt_rdata;
      end
    end
  end

  // Sync pin inputs through two flops, third for edge detect
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trig_sy_ff <= 3'b111;
      clk_sy_ff <= 3'b111;
    end else if (clk_en) begin
      trig_sy_ff <= {trig_sy_ff[1:0], trig_sync_in};
      clk_sy_ff <= {clk_sy_ff[1:0], clk_sync_in};
    end
  end

  // Rate generators reload their divisor on each tick
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (clk_en && init_go)) begin
      cnt_a_ff <= RST_RATE_A[DIV_W-1:0];
      cnt_b_ff <= RST_RATE_B[DIV_W-1:0];
    end else if (clk_en) begin
      cnt_a_ff <= tick_a || rate_a_ff[B_RATE_OFF] ?
                  rate_a_ff[DIV_W-1:0] : cnt_a_ff - 1'b1;
      cnt_b_ff <= tick_b || rate_b_ff[B_RATE_OFF] ?
                  rate_b_ff[DIV_W-1:0] : cnt_b_ff - 1'b1;
    end
  end

  // Burst sequencing
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (clk_en && init_go)) begin
      burst_st_ff <= AAHRM_BURST_IDLE;
      bcnt_ff <= ZERO32;
      samp_strobe_ff <= 1'b0;
    end else if (clk_en) begin
      samp_strobe_ff <= samp_go;
      unique case (burst_st_ff)
        AAHRM_BURST_IDLE: begin
          bcnt_ff <= ZERO32;
          if (burst_start) begin
            burst_st_ff <= AAHRM_BURST_RUN;
          end
        end
        AAHRM_BURST_RUN: begin
          if (burst_end) begin
            burst_st_ff <= AAHRM_BURST_IDLE;
          end else if (samp_go) begin
            bcnt_ff <= bcnt_ff + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // Initiator pulses, driven low for the sync width
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tpulse_ff <= 8'h00;
      cpulse_ff <= 8'h00;
    end else if (clk_en) begin
      if (burst_start && scan_ff[B_TRG_OUT] && tsrc != TSRC_EXT) begin
        tpulse_ff <= 8'(SYNC_PULSE_CYC);
      end else if (tpulse_ff != 8'h00) begin
        tpulse_ff <= tpulse_ff - 8'h01;
      end
      if (samp_go && scan_ff[B_CLK_OUT] && csrc != CSRC_EXT) begin
        cpulse_ff <= 8'(SYNC_PULSE_CYC);
      end else if (cpulse_ff != 8'h00) begin
        cpulse_ff <= cpulse_ff - 8'h01;
      end
    end
  end
  assign trig_sync_out = 1'b0;
  assign trig_sync_oe_n = tpulse_ff == 8'h00;
  assign clk_sync_out = 1'b0;
  assign clk_sync_oe_n = cpulse_ff == 8'h00;
endmodule : aahrm_regbank
`default_nettype wire

// ---- inc/aahrm_pkg.sv ----
// Constants for the acquisition board host register bank.
// Assumes a longword-only local bus behind the host bus bridge.
`default_nettype none
package aahrm_pkg;
  localparam int ADDR_W = 9;
  localparam logic [8:0] OFS_CTRL = 9'h000;
  localparam logic [8:0] OFS_IRQ = 9'h004;
  localparam logic [8:0] OFS_FIFO = 9'h008;
  localparam logic [8:0] OFS_THR = 9'h00C;
  localparam logic [8:0] OFS_RATE_A = 9'h010;
  localparam logic [8:0] OFS_RATE_B = 9'h014;
  localparam logic [8:0] OFS_FILL = 9'h018;
  localparam logic [8:0] OFS_BURST = 9'h01C;
  localparam logic [8:0] OFS_SCAN = 9'h020;
  localparam logic [8:0] OFS_SPAN = 9'h024;
  localparam logic [8:0] OFS_BUILD = 9'h028;
  localparam logic [8:0] OFS_CAL = 9'h02C;
  localparam logic [8:0] OFS_SPARE = 9'h030;
  localparam logic [8:0] OFS_AUX = 9'h034;
  localparam logic [8:0] OFS_MARK_HI = 9'h038;
  localparam logic [8:0] OFS_MARK_LO = 9'h03C;
  localparam logic [8:0] NORMAL_TOP = 9'h040;
  localparam logic [8:0] DIRECT_BASE = 9'h100;
  localparam logic [31:0] RST_CTRL = 32'h0000_4060;
  localparam logic [31:0] RST_IRQ = 32'h0000_0008;
  localparam logic [31:0] RST_THR = 32'h0003_FFFE;
  localparam logic [31:0] RST_RATE_A = 32'h0001_07D0;
  localparam logic [31:0] RST_RATE_B = 32'h0001_EA60;
  localparam logic [31:0] RST_BURST = 32'h0000_0001;
  localparam logic [31:0] RST_SCAN = 32'h0000_0005;
  localparam logic [31:0] RST_SPAN = 32'h0000_0100;
  localparam logic [31:0] RST_CAL = 32'h0000_0800;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  // Control word bits
  localparam int B_HOLD = 10;
  localparam int B_TRIG = 12;
  localparam int B_ACAL = 13;
  localparam int B_PASS = 14;
  localparam int B_INIT = 15;
  localparam int B_UNDER = 16;
  localparam int B_OVER = 17;
  localparam int B_ICLK = 19;
  localparam logic [31:0] CTRL_RW_MASK = 32'h000F_BBFF;
  // Interrupt word: enables in [3:0], sticky flags in [11:8]
  localparam int IRQ_N = 4;
  localparam int IRQ_FLAG_LSB = 8;
  localparam int EV_INIT = 0;
  localparam int EV_BSTART = 1;
  localparam int EV_BDONE = 2;
  localparam int EV_THR = 3;
  // Buffer control: threshold in [17:0], clear in bit 18
  localparam int THR_W = 18;
  localparam int B_BUF_CLR = 18;
  // Rate generator: divisor [15:0], disable bit 16
  localparam int DIV_W = 16;
  localparam int B_RATE_OFF = 16;
  // Scan control fields
  localparam int CLK_SRC_LSB = 3;
  localparam int TRG_SRC_LSB = 5;
  localparam int B_CLK_OUT = 7;
  localparam int B_TRG_OUT = 8;
  localparam logic [1:0] CSRC_RATE_A = 2'h0;
  localparam logic [1:0] CSRC_RATE_B = 2'h1;
  localparam logic [1:0] CSRC_EXT = 2'h2;
  localparam logic [1:0] CSRC_CTRL = 2'h3;
  localparam logic [1:0] TSRC_NONE = 2'h0;
  localparam logic [1:0] TSRC_EXT = 2'h1;
  localparam logic [1:0] TSRC_CTRL = 2'h2;
  localparam logic [1:0] TSRC_RATE_B = 2'h3;
  // Sync pulse width
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SYNC_PULSE_NS = 140;
  localparam int SYNC_PULSE_CYC =
    (SYNC_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic {
    AAHRM_BURST_IDLE = 1'b0,
    AAHRM_BURST_RUN = 1'b1
  } aahrm_burst_t;
endpackage : aahrm_pkg
`default_nettype wire

// ---- tb/aahrm_regbank_checker.sv ----
// Port assertions for the acquisition register bank.
// Assumes clk_en stays high and the strap pins hold still.
`timescale 1ns/10ps
`default_nettype none
module aahrm_regbank_checker
  import aahrm_pkg::*;
#(
  parameter logic [7:0] FW_REV = 8'h01
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] lb_addr,
  input wire logic lb_rd,
  input wire logic lb_wr,
  input wire logic [31:0] lb_rdata_ff,
  input wire logic lb_ack_ff,
  input wire logic lb_hit,
  input wire logic direct_mode_sel,
  input wire logic [7:0] option_straps,
  input wire logic trig_sync_out,
  input wire logic trig_sync_oe_n,
  input wire logic clk_sync_out,
  input wire logic clk_sync_oe_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  int low_cnt_ff;
  // Length of the current trigger drive, in cycles
  always_ff @(posedge sys_clk) begin
    low_cnt_ff <= (sys_rst || trig_sync_oe_n) ? 0 : low_cnt_ff + 1;
  end
  sequence s_req;
    clk_en && (lb_rd || lb_wr);
  endsequence
  sequence s_build_rd;
    lb_rd && lb_addr[8:2] == OFS_BUILD[8:2];
  endsequence
  a_ack_after_req: assert property (s_req |=> lb_ack_ff)
    else $error("ack missing");
  a_ack_has_cause: assert property (lb_ack_ff |-> $past(lb_rd) || $past(lb_wr))
    else $error("ack without request");
  a_window_normal: assert property (!direct_mode_sel |-> lb_hit == (lb_addr < NORMAL_TOP))
    else $error("normal window decode");
  a_window_direct: assert property (direct_mode_sel |-> lb_hit)
    else $error("direct window decode");
  a_reserved_zero: assert property (lb_rd && lb_addr >= NORMAL_TOP && lb_addr < DIRECT_BASE
    |=> lb_rdata_ff == ZERO32)
    else $error("reserved read not zero");
  a_rdata_holds: assert property (!lb_rd |=> $stable(lb_rdata_ff))
    else $error("read data moved");
  a_build_straps: assert property (s_build_rd
    |=> lb_rdata_ff[15:0] == {FW_REV, $past(option_straps)})
    else $error("build word wrong");
  a_trig_pulse_len: assert property ($rose(trig_sync_oe_n) |-> low_cnt_ff == SYNC_PULSE_CYC)
    else $error("trigger pulse length");
  a_trig_drive_low: assert property (!trig_sync_oe_n |-> !trig_sync_out)
    else $error("trigger not driven low");
  a_clk_drive_low: assert property (!clk_sync_oe_n |-> !clk_sync_out)
    else $error("clock pin not driven low");
endmodule : aahrm_regbank_checker
bind aahrm_regbank aahrm_regbank_checker #(.FW_REV(FW_REV)) chk_u (.sys_clk, .sys_rst,
  .clk_en, .lb_addr, .lb_rd, .lb_wr, .lb_rdata_ff, .lb_ack_ff, .lb_hit,
  .direct_mode_sel, .option_straps, .trig_sync_out, .trig_sync_oe_n,
  .clk_sync_out, .clk_sync_oe_n);
`default_nettype wire

// ---- tb/aahrm_peer.sv ----
// Sample source and a second board on the sync pins.
// Driven by bench task calls; pins change at falling edges, except in clk_pulses, which toggles every 62.5 ns.
`timescale 1ns/10ps
`default_nettype none
module aahrm_peer (
  input wire logic sys_clk,
  input wire logic samp_ready,
  output logic samp_valid,
  output logic [17:0] samp_data,
  output logic [5:0] samp_chan,
  input wire logic trig_sync_out,
  input wire logic trig_sync_oe_n,
  input wire logic clk_sync_out,
  input wire logic clk_sync_oe_n,
  output logic trig_sync_in,
  output logic clk_sync_in
);
  logic peer_trig = 1'b1;
  logic peer_clk = 1'b1;
  // Pulled high; either board may only pull low
  assign trig_sync_in = (trig_sync_oe_n | trig_sync_out) & peer_trig;
  assign clk_sync_in = (clk_sync_oe_n | clk_sync_out) & peer_clk;
  initial begin
    samp_valid = 1'b0;
    samp_data = 18'h0;
    samp_chan = 6'h0;
  end
  // Gives up after 50 cycles so an overflow can be provoked
  task automatic push(input logic [17:0] d);
    int n;
    @(negedge sys_clk);
    samp_valid = 1'b1;
    samp_data = d;
    samp_chan = d[5:0];
    n = 0;
    // Ready judged before the taking edge, so a word is never sent twice
    while (!samp_ready && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    samp_valid = 1'b0;
    samp_data = ~d;
  endtask : push
  task automatic trig_pulse();
    @(negedge sys_clk);
    peer_trig = 1'b0;
    repeat (40) @(negedge sys_clk);
    peer_trig = 1'b1;
  endtask : trig_pulse
  task automatic clk_pulses(input int n);
    repeat (n) begin
      #62.5 peer_clk = 1'b0;
      #62.5 peer_clk = 1'b1;
    end
  endtask : clk_pulses
endmodule : aahrm_peer
`default_nettype wire

// ---- tb/analog_acq_host_register_map_tb.sv ----
// Self-checking bench for the acquisition register bank.
// Assumes the peer model drives the stream and the sync pins.
`timescale 1ns/10ps
`default_nettype none
module analog_acq_host_register_map_tb
  import aahrm_pkg::*;
;
  localparam int FDEPTH = 16;
  localparam logic [7:0] FW_ARB = 8'h5A; // Arbitrary revision value
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [8:0] lb_addr = 9'h000;
  logic lb_rd = 1'b0;
  logic lb_wr = 1'b0;
  logic [31:0] lb_wdata = 32'h0000_0000;
  logic direct_mode_sel = 1'b0;
  logic [7:0] option_straps = 8'hC3;
  wire logic [31:0] lb_rdata_ff, aux_sync_ctrl;
  wire logic lb_ack_ff, lb_hit, irq_req, dma_req, samp_valid, samp_ready;
  wire logic [17:0] samp_data;
  wire logic [5:0] samp_chan;
  wire logic samp_strobe_ff, trig_sync_in, trig_sync_out, trig_sync_oe_n;
  wire logic clk_sync_in, clk_sync_out, clk_sync_oe_n;
  wire logic [4:0] watch = {samp_ready, dma_req, irq_req, trig_sync_oe_n, clk_sync_oe_n};
  int mismatches = 0;
  int compares = 0;
  int strobes = 0;
  logic [8:0] ofs [14] = '{OFS_CTRL, OFS_IRQ, OFS_THR, OFS_RATE_A, OFS_RATE_B,
    OFS_FILL, OFS_BURST, OFS_SCAN, OFS_SPAN, OFS_CAL, OFS_SPARE, OFS_AUX,
    OFS_MARK_HI, OFS_MARK_LO};
  logic [31:0] dflt [14] = '{RST_CTRL, RST_IRQ, RST_THR, RST_RATE_A, RST_RATE_B,
    ZERO32, RST_BURST, RST_SCAN, RST_SPAN, RST_CAL, ZERO32, ZERO32, ZERO32, ZERO32};
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (samp_strobe_ff) strobes++;
  aahrm_regbank #(.FIFO_DEPTH(FDEPTH), .FIFO_AW(4), .FW_REV(FW_ARB)) dut_u (
    .sys_clk, .sys_rst, .clk_en, .lb_addr, .lb_rd, .lb_wr, .lb_wdata,
    .lb_rdata_ff, .lb_ack_ff, .lb_hit, .direct_mode_sel, .irq_req, .dma_req,
    .samp_valid, .samp_ready, .samp_data, .samp_chan, .samp_strobe_ff,
    .option_straps, .trig_sync_in, .trig_sync_out, .trig_sync_oe_n,
    .clk_sync_in, .clk_sync_out, .clk_sync_oe_n, .aux_sync_ctrl);
  aahrm_peer peer_u (.sys_clk, .samp_ready, .samp_valid, .samp_data, .samp_chan,
    .trig_sync_out, .trig_sync_oe_n, .clk_sync_out, .clk_sync_oe_n,
    .trig_sync_in, .clk_sync_in);
  task automatic test_done();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic stall();
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask : stall
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One-cycle strobe; answer is due on the next cycle
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(negedge sys_clk);
    lb_addr = a;
    lb_wdata = d;
    lb_rd = !w;
    lb_wr = w;
    @(negedge sys_clk);
    lb_rd = 1'b0;
    lb_wr = 1'b0;
    for (n = 0; n < 8 && lb_ack_ff !== 1'b1; n++) @(negedge sys_clk);
    if (n == 8) stall();
    q = lb_rdata_ff;
  endtask : bus
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [8:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, ZERO32, q);
    chk(q, e);
  endtask : rc
  task automatic till(input int i, input logic v);
    int n;
    for (n = 0; n < 300 && watch[i] !== v; n++) @(negedge sys_clk);
    if (n == 300) stall();
  endtask : till
  task automatic init_brd();
    wr(OFS_CTRL, RST_CTRL | 32'h0000_8000);
    repeat (4) @(negedge sys_clk);
  endtask : init_brd
  initial begin
    logic [31:0] q;
    int i;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (i = 0; i < 14; i++) rc(ofs[i], dflt[i]);
    wr(OFS_CTRL, ZERO32);
    rc(OFS_CTRL, 32'h0000_4000);
    wr(OFS_CTRL, RST_CTRL);
    wr(OFS_FILL, 32'h0000_FFFF);
    rc(OFS_FILL, ZERO32);
    wr(OFS_MARK_HI, 32'hABCD_9876);
    rc(OFS_MARK_HI, 32'h0000_9876);
    wr(OFS_AUX, 32'h1234_5678);
    @(negedge sys_clk);
    chk(aux_sync_ctrl, 32'h1234_5678);
    wr(OFS_BURST, 32'h0000_0010);
    rc(OFS_BURST, 32'h0000_0010);
    bus(1'b0, OFS_BUILD, ZERO32, q);
    chk({16'h0000, q[15:0]}, {16'h0000, FW_ARB, option_straps});
    rc(NORMAL_TOP, ZERO32);
    direct_mode_sel = 1'b1;
    rc(9'h080, ZERO32);
    lb_addr = DIRECT_BASE;
    @(negedge sys_clk);
    chk({31'h0, lb_hit}, 32'h0000_0001);
    direct_mode_sel = 1'b0;
    @(negedge sys_clk);
    chk({31'h0, lb_hit}, ZERO32);
    wr(OFS_THR, 32'h0000_0001);
    for (i = 0; i < 3; i++) peer_u.push(18'h2_A5A0 + 18'(i));
    repeat (4) @(negedge sys_clk);
    rc(OFS_FILL, 32'h0000_0003);
    chk({31'h0, dma_req}, 32'h0000_0001);
    chk({31'h0, irq_req}, 32'h0000_0001);
    for (i = 0; i < 3; i++) begin
      bus(1'b0, OFS_FIFO, ZERO32, q);
      chk({14'h0, q[17:0]}, {14'h0, 18'h2_A5A0 + 18'(i)});
    end
    chk({31'h0, dma_req}, ZERO32);
    rc(OFS_FIFO, ZERO32);
    rc(OFS_CTRL, RST_CTRL | 32'h0001_0000);
    wr(OFS_CTRL, RST_CTRL);
    wr(OFS_IRQ, RST_IRQ);
    chk({31'h0, irq_req}, ZERO32);
    // Far side keeps offering while the buffer is full
    for (i = 0; i < FDEPTH + 3; i++) peer_u.push(18'(i));
    chk({31'h0, samp_ready}, ZERO32);
    rc(OFS_FILL, 32'(FDEPTH));
    rc(OFS_CTRL, RST_CTRL | 32'h0002_0000);
    wr(OFS_IRQ, RST_IRQ);
    wr(OFS_SCAN, 32'h0000_0025);
    peer_u.trig_pulse();
    repeat (6) @(negedge sys_clk);
    bus(1'b0, OFS_IRQ, ZERO32, q);
    chk(q & 32'h0000_0200, 32'h0000_0200);
    wr(OFS_RATE_A, 32'h0000_0100);
    init_brd();
    rc(OFS_CTRL, RST_CTRL);
    rc(OFS_RATE_A, RST_RATE_A);
    rc(OFS_IRQ, RST_IRQ | 32'h0000_0100);
    wr(OFS_SCAN, 32'h0000_0145);
    wr(OFS_CTRL, RST_CTRL | 32'h0000_1000);
    till(1, 1'b0);
    for (i = 0; i < 100 && trig_sync_oe_n === 1'b0; i++) @(negedge sys_clk);
    chk(32'(i), 32'(SYNC_PULSE_CYC));
    init_brd();
    wr(OFS_SCAN, 32'h0000_0015);
    strobes = 0;
    peer_u.clk_pulses(4);
    repeat (8) @(negedge sys_clk);
    chk(32'(strobes), 32'h0000_0004);
    wr(OFS_SCAN, 32'h0000_009D);
    wr(OFS_CTRL, RST_CTRL | 32'h0008_0000);
    till(0, 1'b0);
    test_done();
  end
endmodule : analog_acq_host_register_map_tb
`default_nettype wire
